// >>> common/cog_ctrl_regs.svh
// Purpose: offsets, field positions, reset values of the output control block
// Assumes: APB byte addresses, one 32-bit word per register
// Notes: definitions only
`ifndef COG_CTRL_REGS_SVH
`define COG_CTRL_REGS_SVH
// ----------------------------------------
// Register indices (byte address = index*4)
// ----------------------------------------
`define IX_CON0   6'd0
`define IX_CON1   6'd1
`define IX_SDC    6'd2
`define IX_SDS    6'd3
`define IX_PIN    6'd4
`define IX_CNT0   6'd5
`define IX_CNT5   6'd10
`define IX_STAT   6'd11
`define IX_MASK   6'd12
// ----------------------------------------
// Field positions
// ----------------------------------------
`define C0_EN     7
`define C0_LD     6
`define C0_CS_HI  4
`define C0_CS_LO  3
`define SD_REQ    7
`define SD_ARS    6
`define SD_BD_HI  5
`define SD_BD_LO  4
`define SD_AC_HI  3
`define SD_AC_LO  2
// ----------------------------------------
// Masks, reset values, codes and counts
// ----------------------------------------
`define C0_WMASK  8'hdf
`define C1_WMASK  8'hcf
`define REG_RST   8'h00
`define CS_DIV4   2'b00
`define CS_SYS    2'b01
`define CS_OSC    2'b10
`define DIV4_LAST 2'd3
`define OV_INACT  2'b00
`define OV_TRI    2'b01
`define OV_LOW    2'b10
`define OV_HIGH   2'b11
`endif

// >>> common/cog_ctrl_pkg.sv
// Purpose: types shared by the output control block
// Assumes: eight-bit registers
// Notes: constants live in cog_ctrl_regs.svh
package cog_ctrl_pkg;
	typedef enum logic [0:0] {GEN_SHUT = 1'b0, GEN_RUN = 1'b1} gen_state_t;
	// Configuration handed to the counter and steering logic
	typedef struct packed {
		logic       enable;
		logic [1:0] clk_sel;
		logic [2:0] mode_select;
		logic       rise_deadband_source;
		logic       fall_deadband_source;
	} cfg_t;
	// Working buffers: rise/fall phase, dead-band, blanking
	typedef struct packed {
		logic [7:0] rise_phase_count;
		logic [7:0] fall_phase_count;
		logic [7:0] rise_deadband_count;
		logic [7:0] fall_deadband_count;
		logic [7:0] rise_blank_count;
		logic [7:0] fall_blank_count;
	} counts_t;
	typedef struct packed {
		logic [7:0]  con0;
		logic [7:0]  con1;
		logic [7:0]  sdc;
		logic [7:0]  sds;
		logic [1:0]  pin_use;
		counts_t     cnt_reg;
		counts_t     cnt_buf;
		logic [2:0]  stat;
		logic [2:0]  mask;
		logic [1:0]  div;
		logic        osc_prev;
		logic        rise_prev;
		logic        fall_prev;
		gen_state_t  gen;
		logic        drive;
		logic [3:0]  lvl;
		logic [3:0]  oe;
		logic        irq;
		logic        osc_keep;
		logic [31:0] rdata;
		logic        rdy;
		logic        err;
	} state_t;
endpackage

// >>> rtl/cog_sync.sv
// Purpose: two-flop synchroniser for levels from outside the clock domain
// Assumes: synchronous active-high reset
// Notes: first stage feeds only the second stage
`timescale 1ns/1ps
module cog_sync #(
	parameter int W = 2
) (
	input  wire logic         sys_clk_in,
	input  wire logic         rst_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [2*W-1:0] s_q;
	logic [2*W-1:0] s_d;
	// Shift the two stages
	always_comb
	begin
		s_d = {s_q[W-1:0], d_in};
	end
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign q_out = s_q[2*W-1:W];
endmodule

// >>> rtl/cog_ctrl.sv
// Purpose: control part of a complementary output generator, APB registers
// Assumes: 20 MHz sys_clk_in, events and fault sources from same-clock logic
// Notes: counters and steering sit outside; they read the buffers and config
// Overview of operation
// - After the clear, outputs resume only at the next rising event.
// - shutdown_request stays set while the module is enabled and any enabled fault source is asserted.
// - With auto restart, hardware clears the request once faults go away.
// - Disabled module: count writes reach the working buffers at once.
// - Enabled module: count writes wait for a load request.
// - load_request copies all counts on the next event, then self-clears.
// - Generator runs in sleep; fast oscillator kept on when selected.
// - One pin input usable as rise, fall or fault source.
// - Clock select: 00 sys/4, 01 sys, 10 fast oscillator, 11 reserved.
// - Mode field selects steered, sync steered, bridges, half-bridge, push-pull.
// - Control1 bits 7 and 6 pick delay chain or clock for dead-band.
// - Control1 bits 3..0 make outputs D..A active low when one.
// - Setting shutdown_request forces shutdown with overrides on outputs.
// - Enabled fault sources are level sensitive, active when low.
//
// The APB register port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "cog_ctrl_regs.svh"
module cog_ctrl
	import cog_ctrl_pkg::*;
(
	input  wire logic        sys_clk_in,
	input  wire logic        rst_in,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        pin_in,
	input  wire logic        osc_in,
	input  wire logic        rise_src_in,
	input  wire logic        fall_src_in,
	input  wire logic [6:0]  fault_src_in,
	output logic      [3:0]  out_level_out,
	output logic      [3:0]  out_oe_out,
	output counts_t          counts_out,
	output cfg_t             cfg_out,
	output logic             gen_running_out,
	output logic             osc_keep_out,
	output logic             irq_out
);
	state_t     q;
	state_t     n;
	logic [1:0] sync_s;
	logic       pin_s;
	logic       osc_s;
	logic       wr;
	logic [5:0] idx;
	logic [7:0] wd;
	logic [7:0] src;
	logic       fault;
	logic       tick;
	logic       rise_lvl;
	logic       fall_lvl;
	logic       rise_p;
	logic       fall_p;
	logic       en;
	logic       ld_set;

	// Override level for one output
	function automatic logic [1:0] ovr(input logic [1:0] code, input logic pol);
		logic [1:0] r;
		r = 2'b10;
		case (code)
			`OV_INACT: r = {1'b1, pol};
			`OV_TRI:   r = 2'b00;
			`OV_LOW:   r = 2'b10;
			`OV_HIGH:  r = 2'b11;
			default:   r = 2'b10;
		endcase
		return r;
	endfunction

	// ----------------------------------------
	// Asynchronous pin and oscillator inputs
	// ----------------------------------------
	cog_sync #(
		.W(2)
	) u_sync (
		.sys_clk_in(sys_clk_in),
		.rst_in    (rst_in),
		.d_in      ({osc_in, pin_in}),
		.q_out     (sync_s)
	);
	assign pin_s = sync_s[0];
	assign osc_s = sync_s[1];

	// ----------------------------------------
	// Next-state logic
	// ----------------------------------------
	always_comb
	begin
		n = q;
		en = q.con0[`C0_EN];
		idx = paddr[7:2];
		wd = pwdata[7:0];
		wr = psel & penable & pwrite & q.rdy & ~q.err;
		ld_set = 1'b0;
		// pin shared as rise, fall or fault
		rise_lvl = rise_src_in | (q.pin_use[0] & pin_s);
		fall_lvl = fall_src_in | (q.pin_use[1] & pin_s);
		src = {fault_src_in, pin_s};
		// low level of enabled source faults
		fault = en & (|(~src & q.sds));
		case (q.con0[`C0_CS_HI:`C0_CS_LO])
			`CS_DIV4: tick = (q.div == `DIV4_LAST);
			`CS_SYS:  tick = 1'b1;
			`CS_OSC:  tick = osc_s & ~q.osc_prev;
			default:  tick = 1'b0;
		endcase
		n.div = q.div + 2'd1;
		n.osc_prev = osc_s;
		if (tick)
		begin
			n.rise_prev = rise_lvl;
			n.fall_prev = fall_lvl;
		end
		rise_p = tick & rise_lvl & ~q.rise_prev;
		fall_p = tick & fall_lvl & ~q.fall_prev;
		// Register writes
		if (wr)
		begin
			case (idx)
				`IX_CON0:
				begin
					n.con0 = wd & `C0_WMASK;
					n.con0[`C0_LD] = q.con0[`C0_LD];
					ld_set = wd[`C0_LD];
				end
				`IX_CON1: n.con1 = wd & `C1_WMASK;
				`IX_SDC:  n.sdc = wd & 8'hfc;
				`IX_SDS:  n.sds = wd;
				`IX_PIN:  n.pin_use = wd[1:0];
				`IX_STAT: n.stat = q.stat & ~wd[2:0];
				`IX_MASK: n.mask = wd[2:0];
				default:
				begin
					if (idx >= `IX_CNT0 && idx <= `IX_CNT5)
						n.cnt_reg[8*(`IX_CNT5-idx) +: 8] = wd;
				end
			endcase
		end
		// fault keeps request set, beats a clear
		if (fault)
			n.sdc[`SD_REQ] = 1'b1;
		// auto restart clears request once faults gone
		else if (q.sdc[`SD_ARS] & q.sdc[`SD_REQ])
			n.sdc[`SD_REQ] = 1'b0;
		// Generator state
		case (q.gen)
			GEN_RUN:
			begin
				if (~en | q.sdc[`SD_REQ] | fault)
				begin
					n.gen = GEN_SHUT;
					n.drive = 1'b0;
					n.stat[0] = 1'b1;
				end
				else if (rise_p)
					n.drive = 1'b1;
				else if (fall_p)
					n.drive = 1'b0;
			end
			GEN_SHUT:
			begin
				n.drive = 1'b0;
				// leave only on a rising event after clear
				if (en & ~q.sdc[`SD_REQ] & ~fault & rise_p)
				begin
					n.gen = GEN_RUN;
					n.drive = 1'b1;
					n.stat[1] = 1'b1;
				end
			end
			default: n.gen = GEN_SHUT;
		endcase
		if (~en)
		begin
			n.cnt_buf = n.cnt_reg;
			n.con0[`C0_LD] = 1'b0;
		end
		// load on next event, then clear in hardware
		else if (q.con0[`C0_LD] & (rise_p | fall_p))
		begin
			n.cnt_buf = q.cnt_reg;
			n.con0[`C0_LD] = 1'b0;
			n.stat[2] = 1'b1;
		end
		// enabled: buffers held until load request
		if (ld_set)
			n.con0[`C0_LD] = 1'b1;
		for (int i = 0; i < 4; i++)
		begin
			n.lvl[i] = (n.drive ^ i[0]) ^ n.con1[i];
			n.oe[i] = n.con0[`C0_EN];
			if (n.gen == GEN_SHUT)
			begin
				// Pair A/C and pair B/D share an override code
				if (i[0])
					{n.oe[i], n.lvl[i]} = ovr(n.sdc[`SD_BD_HI:`SD_BD_LO], n.con1[i] ^ 1'b1);
				else
					{n.oe[i], n.lvl[i]} = ovr(n.sdc[`SD_AC_HI:`SD_AC_LO], n.con1[i]);
				n.oe[i] = n.oe[i] & n.con0[`C0_EN];
			end
		end
		n.irq = |(n.stat & n.mask);
		// oscillator kept on through sleep when it clocks us
		n.osc_keep = n.con0[`C0_EN] & (n.con0[`C0_CS_HI:`C0_CS_LO] == `CS_OSC);
		// APB: answer in the first access cycle
		n.rdy = psel & ~penable;
		n.err = 1'b0;
		n.rdata = '0;
		if (psel & ~penable)
		begin
			case (idx)
				`IX_CON0: n.rdata[7:0] = q.con0;
				`IX_CON1: n.rdata[7:0] = q.con1;
				`IX_SDC:  n.rdata[7:0] = q.sdc;
				`IX_SDS:  n.rdata[7:0] = q.sds;
				`IX_PIN:  n.rdata[1:0] = q.pin_use;
				`IX_STAT: n.rdata[2:0] = q.stat;
				`IX_MASK: n.rdata[2:0] = q.mask;
				default:
				begin
					if (idx >= `IX_CNT0 && idx <= `IX_CNT5)
						n.rdata[7:0] = q.cnt_reg[8*(`IX_CNT5-idx) +: 8];
					else
						n.err = 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			q <= '0;
			q.gen <= GEN_SHUT; // start from shutdown
		end
		else
			q <= n;
	end

	// Outputs straight from flops
	assign prdata = q.rdata;
	assign pready = q.rdy;
	assign pslverr = q.err;
	assign out_level_out = q.lvl;
	assign out_oe_out = q.oe;
	assign counts_out = q.cnt_buf;
	// mode and dead-band source handed on
	assign cfg_out = {q.con0[`C0_EN], q.con0[`C0_CS_HI:`C0_CS_LO], q.con0[2:0],
		q.con1[7], q.con1[6]};
	// Run state is a single flop bit, GEN_RUN encodes as one
	assign gen_running_out = q.gen;
	assign osc_keep_out = q.osc_keep;
	assign irq_out = q.irq;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);

	AST_HOLD_SHUT: assert property ((q.gen == GEN_SHUT) && !rise_p |=> q.gen == GEN_SHUT)
		else $error("left shutdown without rising event");
	AST_RESUME: assert property (en && (q.gen == GEN_SHUT) && !q.sdc[`SD_REQ] && !fault && rise_p
		|=> (q.gen == GEN_RUN) && q.drive)
		else $error("no resume on rising event");
	AST_REQ_STICK: assert property (fault |=> q.sdc[`SD_REQ] && (q.gen == GEN_SHUT))
		else $error("request cleared under fault");
	AST_AUTO_CLR: assert property (q.sdc[`SD_ARS] && q.sdc[`SD_REQ] && !fault
		&& !(wr && idx == `IX_SDC) |=> !q.sdc[`SD_REQ])
		else $error("auto restart did not clear request");
	AST_LOAD_DIS: assert property (!en |=> q.cnt_buf == q.cnt_reg)
		else $error("buffers not following while disabled");
	AST_LOAD_HOLD: assert property (en && !q.con0[`C0_LD] |=> $stable(q.cnt_buf))
		else $error("buffers changed without load request");
	AST_LOAD_XFER: assert property (en && q.con0[`C0_LD] && (rise_p || fall_p)
		|=> q.cnt_buf == $past(q.cnt_reg) && q.stat[2])
		else $error("load request transfer wrong");
	AST_OSC_KEEP: assert property (en && q.con0[4:3] == `CS_OSC ##1 $stable(q.con0)
		|-> osc_keep_out)
		else $error("oscillator keep not set");
	AST_BIT5: assert property (q.con0[5] == 1'b0)
		else $error("unimplemented bit set");
	AST_SYS_TICK: assert property (q.con0[4:3] == `CS_SYS |-> tick)
		else $error("system clock select not ticking");
	AST_POL: assert property ((q.gen == GEN_RUN) |-> q.lvl[0] == (q.drive ^ q.con1[0])
		&& q.lvl[1] == (!q.drive ^ q.con1[1]))
		else $error("polarity wrong");
	AST_FORCE: assert property (en && q.sdc[`SD_REQ] |=> q.gen == GEN_SHUT && !q.drive)
		else $error("request did not force shutdown");

	COV_RESUME: cover property ((q.gen == GEN_SHUT) ##1 (q.gen == GEN_RUN));
	COV_FAULT: cover property ((q.gen == GEN_RUN) && fault ##1 (q.gen == GEN_SHUT));
	COV_AUTO: cover property (q.sdc[`SD_ARS] && q.sdc[`SD_REQ] ##1 !q.sdc[`SD_REQ]);
	COV_LOAD: cover property (en && q.con0[`C0_LD] ##1 !q.con0[`C0_LD]);
endmodule

// >>> dv/power_stage.sv
// Purpose: power stage model hung on the four generator pins
// Assumes: one clock; a pin is driven only while its enable is high
// Notes: a floating pin toggles between 0x5 and 0xa each cycle instead of holding a stale level
`timescale 1ns/1ps
module power_stage (
	input  wire logic       sys_clk_in,
	input  wire logic [3:0] level_in,
	input  wire logic [3:0] oe_in,
	output logic      [3:0] pin_out
);
	// ----------------------------------------
	// Gate levels
	// ----------------------------------------
	logic [3:0] float_q = 4'h5;
	// Undriven gates wander, not hold
	always_ff @(posedge sys_clk_in)
		float_q <= ~float_q;
	// Level seen per gate
	always_comb
		for (int i = 0; i < 4; i++)
			pin_out[i] = oe_in[i] ? level_in[i] : float_q[i];
endmodule

// >>> dv/complementary_output_control_tb_top.sv
// Purpose: self-checking bench for the output control block
// Assumes: zero-wait APB slave, events on same clock, clock select 01
// Notes: oscillator is held still; pin input is driven only in the shared pin test
`timescale 1ns/1ps
module complementary_output_control_tb_top
	import cog_ctrl_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic        sys_clk_in = 1'b0;
	logic        rst_in = 1'b1;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd_q;
	logic        pready, pslverr, er_q;
	logic        rise_src_in = 1'b0;
	logic        fall_src_in = 1'b0;
	logic [6:0]  fault_src_in = 7'h7f;
	logic        pin_drv = 1'b1;
	logic [3:0]  out_level_out, out_oe_out, pin_lvl;
	counts_t     counts_out;
	cfg_t        cfg_out;
	logic        gen_running_out, osc_keep_out, irq_out;
	int          err_total = 0;
	int          comparisons = 0;
	// 50 ns period
	initial
	begin
		forever #25 sys_clk_in = ~sys_clk_in;
	end
	cog_ctrl dut_u (.sys_clk_in, .rst_in, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .pin_in(pin_drv), .osc_in(1'b0), .rise_src_in,
		.fall_src_in, .fault_src_in, .out_level_out, .out_oe_out, .counts_out,
		.cfg_out, .gen_running_out, .osc_keep_out, .irq_out);
	power_stage stage_u (.sys_clk_in, .level_in(out_level_out), .oe_in(out_oe_out),
		.pin_out(pin_lvl));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk_in);
	endtask
	// One transfer; waits for pready with no own limit, the watchdog ends a hang
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge sys_clk_in);
		penable <= 1'b1;
		@(posedge sys_clk_in);
		while (pready !== 1'b1)
		begin
			@(posedge sys_clk_in);
		end
		rd_q = prdata;
		er_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge sys_clk_in);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		apb(1'b0, a, 8'h00);
		chk(rd_q, {24'h0, e});
	endtask
	// Level event held over several ticks
	task automatic ev(input logic r);
		if (r)
			rise_src_in <= 1'b1;
		else
			fall_src_in <= 1'b1;
		idle(3);
		rise_src_in <= 1'b0;
		fall_src_in <= 1'b0;
		idle(3);
	endtask
	task automatic finish_test();
		$display("comparisons=%0d mismatches=%0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Hang guard, far beyond the two hundred or so cycles used
	initial
	begin
		repeat (20000) @(posedge sys_clk_in);
		err_total++;
		finish_test();
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial
	begin
		idle(16);
		rst_in <= 1'b0;
		idle(1);
		rd(8'h00, 8'h00);
		apb(1'b0, 8'h40, 8'h00);
		chk({31'h0, er_q}, 32'h1);
		wr(8'h04, 8'hff);
		rd(8'h04, 8'hcf);
		chk({30'h0, cfg_out.rise_deadband_source, cfg_out.fall_deadband_source}, 32'h3);
		wr(8'h04, 8'h00);
		for (int m = 0; m < 6; m++)
		begin
			wr(8'h00, 8'h08 | m[7:0]);
			chk({29'h0, cfg_out.mode_select}, m);
		end
		wr(8'h00, 8'h2d);
		rd(8'h00, 8'h0d);
		chk({30'h0, cfg_out.clk_sel}, 32'h1);
		wr(8'h00, 8'h90);
		chk({31'h0, osc_keep_out}, 32'h1);
		wr(8'h00, 8'h00);
		wr(8'h14, 8'ha5);
		chk({24'h0, counts_out.rise_phase_count}, 32'ha5);
		$display("test registers done");
		// Ordered start: request set, overrides A/C low, B/D high
		wr(8'h08, 8'hb8);
		wr(8'h00, 8'h88);
		idle(2);
		chk({28'h0, pin_lvl}, 32'ha);
		wr(8'h18, 8'h3c);
		chk({24'h0, counts_out.fall_phase_count}, 32'h00);
		wr(8'h08, 8'h38);
		idle(3);
		chk({31'h0, gen_running_out}, 32'h0);
		ev(1'b1);
		chk({31'h0, gen_running_out}, 32'h1);
		chk({28'h0, pin_lvl}, 32'h5);
		wr(8'h00, 8'hc8);
		rd(8'h00, 8'hc8);
		ev(1'b0);
		chk({28'h0, pin_lvl}, 32'ha);
		chk({24'h0, counts_out.fall_phase_count}, 32'h3c);
		rd(8'h00, 8'h88);
		wr(8'h04, 8'h0f);
		ev(1'b1);
		chk({28'h0, pin_lvl}, 32'ha);
		wr(8'h04, 8'h00);
		wr(8'h2c, 8'h07);
		$display("test start and load done");
		// Fault on source 1 with software restart
		wr(8'h0c, 8'h02);
		fault_src_in <= 7'h7e;
		idle(3);
		chk({31'h0, gen_running_out}, 32'h0);
		chk({28'h0, pin_lvl}, 32'ha);
		wr(8'h08, 8'h38);
		rd(8'h08, 8'hb8);
		fault_src_in <= 7'h7f;
		wr(8'h08, 8'h38);
		rd(8'h08, 8'h38);
		chk({31'h0, gen_running_out}, 32'h0);
		ev(1'b1);
		chk({31'h0, gen_running_out}, 32'h1);
		wr(8'h30, 8'h01);
		chk({31'h0, irq_out}, 32'h1);
		wr(8'h2c, 8'h01);
		chk({31'h0, irq_out}, 32'h0);
		wr(8'h30, 8'h00);
		$display("test software restart done");
		// Automatic restart
		wr(8'h08, 8'h78);
		fault_src_in <= 7'h7e;
		idle(3);
		rd(8'h08, 8'hf8);
		fault_src_in <= 7'h7f;
		idle(3);
		rd(8'h08, 8'h78);
		chk({31'h0, gen_running_out}, 32'h0);
		ev(1'b1);
		chk({31'h0, gen_running_out}, 32'h1);
		// Shared pin: first as fault source, then as rise source
		wr(8'h0c, 8'h01);
		pin_drv <= 1'b0;
		idle(4);
		chk({31'h0, gen_running_out}, 32'h0);
		wr(8'h0c, 8'h00);
		wr(8'h10, 8'h01);
		chk({31'h0, gen_running_out}, 32'h0);
		pin_drv <= 1'b1;
		idle(4);
		chk({31'h0, gen_running_out}, 32'h1);
		wr(8'h00, 8'h08);
		idle(2);
		chk({28'h0, out_oe_out}, 32'h0);
		$display("test auto restart done");
		finish_test();
	end
endmodule
